//--- src/twsc_pkg.sv
// Constants and types for the three-wire start/stop control block
package twsc_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int PULSE_MIN_MS = 32;
	// Least time rounds down
	localparam int PULSE_MIN_CYC = (CLK_HZ / 1000) * PULSE_MIN_MS;
	localparam int CNT_W = 22;
	localparam logic [CNT_W-1:0] PULSE_MIN_CNT = CNT_W'(PULSE_MIN_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 22'h000000;
	// Control location selections
	localparam logic [5:0] LOC_THREE_WIRE_CONTACTS = 6'h05;
	localparam logic [5:0] three_wire_contacts_or_panel = 6'h2e;
	// Timer operation modes
	localparam logic [1:0] TMR_MODE_OFF = 2'h0;
	localparam logic [1:0] TMR_MODE_DELAY = 2'h1;
	localparam logic [1:0] TMR_MODE_PULSE = 2'h2;
	localparam logic [1:0] TMR_MODE_THRU = 2'h3;
	localparam int TMR_W = 16;
	localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
	// Motor temperature operation modes
	localparam logic [1:0] TEMP_MODE_OFF = 2'h0;
	localparam logic [1:0] TEMP_MODE_WARN = 2'h1;
	localparam logic [1:0] TEMP_MODE_ERR = 2'h2;
	localparam logic [1:0] TEMP_MODE_BOTH = 2'h3;

	typedef enum logic [3:0] {
		TWSC_IDLE = 4'h1,
		TWSC_ARMED = 4'h2,
		TWSC_CHECK = 4'h4,
		TWSC_RUN = 4'h8
	} twsc_state_t;
endpackage

//--- src/twsc_timer.sv
// One selectable logic-signal timer
module twsc_timer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Configuration
	input wire logic [1:0] mode,
	input wire logic [15:0] time_cyc,
	// Signal
	input wire logic src,
	output logic q
);
	typedef struct packed {
		logic [15:0] cnt;
		logic src_d;
		logic q;
	} twsc_tmr_st_t;
	twsc_tmr_st_t st_reg, st_next;

	always_comb begin
		st_next = st_reg;
		st_next.src_d = src;
		case (mode)
			twsc_pkg::TMR_MODE_DELAY: begin
				// On-delay: output follows after src held for time_cyc
				if (!src) begin
					st_next.cnt = twsc_pkg::TMR_ZERO;
					st_next.q = 1'b0;
				end else if (st_reg.cnt >= time_cyc) begin
					st_next.q = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + 16'h0001;
				end
			end
			twsc_pkg::TMR_MODE_PULSE: begin
				// Rising edge gives a pulse of time_cyc cycles
				if (src && !st_reg.src_d) begin
					st_next.cnt = time_cyc;
					st_next.q = (time_cyc != twsc_pkg::TMR_ZERO);
				end else if (st_reg.cnt > 16'h0001) begin
					st_next.cnt = st_reg.cnt - 16'h0001;
				end else begin
					st_next.cnt = twsc_pkg::TMR_ZERO;
					st_next.q = 1'b0;
				end
			end
			twsc_pkg::TMR_MODE_THRU: begin
				st_next.q = src;
			end
			default: begin
				st_next.cnt = twsc_pkg::TMR_ZERO;
				st_next.q = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;
endmodule

//--- src/twsc_top.sv
// Start/stop command logic with three-wire pulse control
// Function
// - The drive is not accelerated until a clockwise or anticlockwise start command arrives.
// - Outside three-wire mode each start input sets the direction and triggers start behaviour, its loss stop behaviour.
// - In three-wire mode a start needs the hold level on and a rising edge on a start input.
// - In three-wire mode an accepted start pulse latches while hold is on and clears when off.
// - In three-wire mode turning the hold level off stops the drive.
// - While running under three-wire control after the pulse check, further start edges are ignored.
// - An accepted start pulse high for less than 32 ms stops the drive.
// - Both start inputs asserted within 32 ms of each other stops the drive.
// - Location selection 5 gives three-wire mode with direction and hold from contacts only.
// - Location selection 46 gives three-wire mode from contacts or the operator panel.
// - A fault is cleared when acknowledged by program command or the acknowledge signal.
// - Two timers each take their own selectable source and their own operation mode.
// - The thermal contact is a threshold input fed to the temperature error/warning handling.
module twsc_top #(
	// Pulse check window in clock cycles
	parameter logic [twsc_pkg::CNT_W-1:0] PULSE_CNT = twsc_pkg::PULSE_MIN_CNT
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Configuration
	input wire logic [5:0] loc_sel,
	input wire logic [1:0] temp_mode,
	// Contact inputs
	input wire logic start_cw,
	input wire logic start_ccw,
	input wire logic hold_lvl,
	// Operator panel inputs
	input wire logic panel_cw,
	input wire logic panel_ccw,
	input wire logic panel_hold,
	// Fault handling
	input wire logic fault_in,
	input wire logic ack_prog,
	input wire logic ack_sig,
	input wire logic therm_contact,
	// Timers
	input wire logic [7:0] tmr_src_bus,
	input wire logic [2:0] tmr1_sel,
	input wire logic [2:0] tmr2_sel,
	input wire logic [1:0] tmr1_mode,
	input wire logic [1:0] tmr2_mode,
	input wire logic [15:0] tmr1_time,
	input wire logic [15:0] tmr2_time,
	// Drive commands
	output logic run,
	output logic dir_ccw,
	output logic start_req,
	output logic stop_req,
	output logic fault,
	output logic temp_err,
	output logic temp_warn,
	output logic tmr1_out,
	output logic tmr2_out
);
	typedef struct packed {
		twsc_pkg::twsc_state_t state;
		logic [twsc_pkg::CNT_W-1:0] cnt;
		logic cw_d;
		logic ccw_d;
		logic run;
		logic dir_ccw;
		logic start_req;
		logic stop_req;
		logic fault;
		logic temp_err;
		logic temp_warn;
	} twsc_st_t;
	twsc_st_t st_reg, st_next;

	logic three_wire, panel_ok, cw_in, ccw_in, hold_in, cw_rise, ccw_rise;
	logic t1_q, t2_q;

	////////////////////////////////////////////////////////////////
	// Source selection
	always_comb begin
		three_wire = (loc_sel == twsc_pkg::LOC_THREE_WIRE_CONTACTS) ||
			(loc_sel == twsc_pkg::three_wire_contacts_or_panel);
		panel_ok = (loc_sel == twsc_pkg::three_wire_contacts_or_panel);
		cw_in = start_cw || (panel_ok && panel_cw);
		ccw_in = start_ccw || (panel_ok && panel_ccw);
		hold_in = hold_lvl || (panel_ok && panel_hold);
		cw_rise = cw_in && !st_reg.cw_d;
		ccw_rise = ccw_in && !st_reg.ccw_d;
	end

	////////////////////////////////////////////////////////////////
	// Start/stop state machine
	always_comb begin
		st_next = st_reg;
		st_next.cw_d = cw_in;
		st_next.ccw_d = ccw_in;
		st_next.start_req = 1'b0;
		st_next.stop_req = 1'b0;
		if (fault_in) begin
			st_next.fault = 1'b1;
		end else if (ack_prog || ack_sig) begin
			st_next.fault = 1'b0;
		end
		st_next.temp_err = therm_contact && temp_mode[1];
		st_next.temp_warn = therm_contact && temp_mode[0];
		if (!three_wire) begin
			// Plain start commands, level driven
			st_next.state = twsc_pkg::TWSC_IDLE;
			st_next.cnt = twsc_pkg::CNT_ZERO;
			if ((cw_in ^ ccw_in) && !st_reg.fault) begin
				if (!st_reg.run || st_reg.dir_ccw != ccw_in) begin
					st_next.start_req = 1'b1;
				end
				st_next.run = 1'b1;
				st_next.dir_ccw = ccw_in;
			end else begin
				if (st_reg.run) begin
					st_next.stop_req = 1'b1;
				end
				st_next.run = 1'b0;
			end
		end else begin
			case (st_reg.state)
				twsc_pkg::TWSC_IDLE: begin
					st_next.stop_req = st_reg.run;
					st_next.run = 1'b0;
					if (hold_in) begin
						st_next.state = twsc_pkg::TWSC_ARMED;
					end
				end
				twsc_pkg::TWSC_ARMED: begin
					if (!hold_in) begin
						st_next.state = twsc_pkg::TWSC_IDLE;
					end else if ((cw_rise || ccw_rise) && !st_reg.fault) begin
						st_next.state = twsc_pkg::TWSC_CHECK;
						st_next.run = 1'b1;
						st_next.start_req = 1'b1;
						st_next.dir_ccw = ccw_rise && !cw_rise;
						// Accept edge and last sample both lie inside the window
						st_next.cnt = PULSE_CNT - 22'h000002;
					end
				end
				twsc_pkg::TWSC_CHECK: begin
					if (!hold_in || st_reg.fault) begin
						st_next.state = twsc_pkg::TWSC_IDLE;
						st_next.run = 1'b0;
						st_next.stop_req = 1'b1;
					end else if (cw_in && ccw_in) begin
						st_next.state = twsc_pkg::TWSC_IDLE;
						st_next.run = 1'b0;
						st_next.stop_req = 1'b1;
					end else if (!(st_reg.dir_ccw ? ccw_in : cw_in)) begin
						st_next.state = twsc_pkg::TWSC_IDLE;
						st_next.run = 1'b0;
						st_next.stop_req = 1'b1;
					end else if (st_reg.cnt == twsc_pkg::CNT_ZERO) begin
						st_next.state = twsc_pkg::TWSC_RUN;
					end else begin
						st_next.cnt = st_reg.cnt - 22'h000001;
					end
				end
				twsc_pkg::TWSC_RUN: begin
					// Edges on start inputs have no effect here
					if (!hold_in || st_reg.fault) begin
						st_next.state = twsc_pkg::TWSC_IDLE;
						st_next.run = 1'b0;
						st_next.stop_req = 1'b1;
					end
				end
				default: begin
					st_next.state = twsc_pkg::TWSC_IDLE;
					st_next.run = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{state: twsc_pkg::TWSC_IDLE, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Timers
	twsc_timer u_tmr1 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.mode(tmr1_mode),
		.time_cyc(tmr1_time),
		.src(tmr_src_bus[tmr1_sel]),
		.q(t1_q)
	);
	twsc_timer u_tmr2 (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.mode(tmr2_mode),
		.time_cyc(tmr2_time),
		.src(tmr_src_bus[tmr2_sel]),
		.q(t2_q)
	);

	assign run = st_reg.run;
	assign dir_ccw = st_reg.dir_ccw;
	assign start_req = st_reg.start_req;
	assign stop_req = st_reg.stop_req;
	assign fault = st_reg.fault;
	assign temp_err = st_reg.temp_err;
	assign temp_warn = st_reg.temp_warn;
	assign tmr1_out = t1_q;
	assign tmr2_out = t2_q;

	////////////////////////////////////////////////////////////////
	// Checks
	chk_run_needs_start: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(run) |-> $past(cw_in || ccw_in))
		else $error("run rose without start input");
	chk_start_needs_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && $rose(run)) |-> $past(hold_in && (cw_rise || ccw_rise)))
		else $error("three-wire start without hold and edge");
	chk_hold_off_stops: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && run && !hold_in) |=> !run)
		else $error("run survived hold release");
	chk_latch_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_RUN && hold_in && !st_reg.fault)
		|=> run)
		else $error("latch lost with hold on");
	chk_edges_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_RUN && hold_in && !st_reg.fault
		&& (cw_rise || ccw_rise)) |=> (run && $stable(dir_ccw)))
		else $error("edge acted while running");
	chk_short_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_CHECK && hold_in && !st_reg.fault
		&& !(cw_in && ccw_in) && !(dir_ccw ? ccw_in : cw_in)) |=> (!run && stop_req))
		else $error("short pulse did not stop");
	chk_both_inputs: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_CHECK && cw_in && ccw_in)
		|=> (!run && stop_req))
		else $error("both inputs did not stop");
	chk_fault_ack: assert property (@(posedge ref_clk) disable iff (!rstn)
		(fault && !fault_in && (ack_prog || ack_sig)) |=> !fault)
		else $error("fault not cleared on ack");
	chk_panel_blocked: assert property (@(posedge ref_clk) disable iff (!rstn)
		(loc_sel == twsc_pkg::LOC_THREE_WIRE_CONTACTS && !start_cw && !start_ccw)
		|-> (!cw_in && !ccw_in))
		else $error("panel input used in contacts-only mode");
	chk_temp_pass: assert property (@(posedge ref_clk) disable iff (!rstn)
		1'b1 |=> (temp_err == $past(therm_contact && temp_mode[1])))
		else $error("thermal error not passed on");
	chk_plain_go: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!three_wire && (cw_in ^ ccw_in) && !st_reg.fault)
		|=> (run && (dir_ccw == $past(ccw_in))))
		else $error("plain start not taken");
	chk_plain_halt: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!three_wire && run && (!(cw_in ^ ccw_in) || st_reg.fault))
		|=> (!run && stop_req))
		else $error("plain stop not taken");
	chk_plain_redir: assert property (@(posedge ref_clk) disable iff (!rstn)
		(!three_wire && run && (cw_in ^ ccw_in) && !st_reg.fault && (dir_ccw != ccw_in))
		|=> start_req)
		else $error("direction change gave no start");
	chk_rise_start: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(run) |-> start_req)
		else $error("run rose without start request");
	chk_fall_stop: assert property (@(posedge ref_clk) disable iff (!rstn)
		$fell(run) |-> stop_req)
		else $error("run fell without stop request");
	chk_armed_only: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state != twsc_pkg::TWSC_ARMED)
		|=> !start_req)
		else $error("three-wire start outside armed state");
	chk_check_to_run: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_CHECK && hold_in && !st_reg.fault
		&& !(cw_in && ccw_in) && (dir_ccw ? ccw_in : cw_in)
		&& st_reg.cnt == twsc_pkg::CNT_ZERO)
		|=> (run && st_reg.state == twsc_pkg::TWSC_RUN))
		else $error("full-length pulse did not run");
	chk_window_counts: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_CHECK && hold_in && !st_reg.fault
		&& !(cw_in && ccw_in) && (dir_ccw ? ccw_in : cw_in)
		&& st_reg.cnt != twsc_pkg::CNT_ZERO)
		|=> (st_reg.cnt == $past(st_reg.cnt) - 22'h000001))
		else $error("pulse window count skipped");
	chk_window_load: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_CHECK && start_req)
		|-> (st_reg.cnt == PULSE_CNT - 22'h000002))
		else $error("pulse window not loaded on start");
	chk_ccw_accept: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && st_reg.state == twsc_pkg::TWSC_ARMED && hold_in && !st_reg.fault
		&& ccw_rise && !cw_rise) |=> (run && dir_ccw))
		else $error("anticlockwise start not taken");
	chk_latch_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
		(three_wire && !hold_in) |=> (st_reg.state == twsc_pkg::TWSC_IDLE))
		else $error("latch kept after hold release");
	chk_panel_used: assert property (@(posedge ref_clk) disable iff (!rstn)
		(loc_sel == twsc_pkg::three_wire_contacts_or_panel && panel_cw && panel_hold)
		|-> (cw_in && hold_in))
		else $error("panel input ignored in panel mode");
	chk_fault_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
		fault_in |=> fault)
		else $error("fault not recorded");
	chk_fault_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
		(fault && !ack_prog && !ack_sig) |=> fault)
		else $error("fault cleared without ack");
	chk_warn_pass: assert property (@(posedge ref_clk) disable iff (!rstn)
		1'b1 |=> (temp_warn == $past(therm_contact && temp_mode[0])))
		else $error("thermal warning not passed on");
	chk_timer_thru: assert property (@(posedge ref_clk) disable iff (!rstn)
		(tmr1_mode == twsc_pkg::TMR_MODE_THRU)
		|=> (tmr1_out == $past(tmr_src_bus[tmr1_sel])))
		else $error("timer one pass-through wrong");
endmodule

//--- verif/twsc_contacts.sv
// Contact and operator-panel model that feeds the control block
module twsc_contacts (
	// Clock
	input wire logic ref_clk,
	// Wanted levels: cw, ccw, hold, panel cw, panel ccw, panel hold
	input wire logic [5:0] want,
	// Contacts
	output logic start_cw,
	output logic start_ccw,
	output logic hold_lvl,
	// Operator panel
	output logic panel_cw,
	output logic panel_ccw,
	output logic panel_hold
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {panel_hold, panel_ccw, panel_cw, hold_lvl, start_ccw, start_cw} = 6'h00;
	// Clean levels, switched between rising edges
	always @(negedge ref_clk) begin
		{panel_hold, panel_ccw, panel_cw, hold_lvl, start_ccw, start_cw} <= want;
	end
endmodule

//--- verif/twsc_top_tb.sv
// Self-checking bench for the three-wire start/stop control block
module twsc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [5:0] CW = 6'h01, CCW = 6'h02, HOLD = 6'h04;
	localparam logic [5:0] PCW = 6'h08, PCCW = 6'h10, PHOLD = 6'h20;
	// Event notes: start_req, stop_req, run, dir_ccw
	localparam logic [3:0] GO_CW = 4'ha, GO_CCW = 4'hb, STOP = 4'h4;
	// Short check window so the run state is reached within the run
	localparam int PCYC = 64;
	localparam logic [21:0] PCNT = 22'h000040;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] loc_sel = 6'h00;
	logic [1:0] temp_mode = 2'h0;
	logic [5:0] want = 6'h00;
	logic fault_in = 1'b0;
	logic ack_prog = 1'b0;
	logic ack_sig = 1'b0;
	logic therm_contact = 1'b0;
	logic [7:0] tmr_src_bus = 8'h00;
	logic [2:0] tmr1_sel = 3'h0, tmr2_sel = 3'h0;
	logic [1:0] tmr1_mode = 2'h0, tmr2_mode = 2'h0;
	logic [15:0] tmr1_time = 16'h0006, tmr2_time = 16'h0004;
	logic start_cw, start_ccw, hold_lvl, panel_cw, panel_ccw, panel_hold;
	logic run, dir_ccw, start_req, stop_req, fault, temp_err, temp_warn, tmr1_out, tmr2_out;
	logic [3:0] notes[$];
	logic [3:0] seen;
	logic [5:0] h, c, a;
	int n_fail = 0;
	int checks = 0;
	int hi, hi2;
	twsc_contacts i_twsc_contacts (.ref_clk(ref_clk), .want(want), .start_cw(start_cw),
		.start_ccw(start_ccw), .hold_lvl(hold_lvl), .panel_cw(panel_cw),
		.panel_ccw(panel_ccw), .panel_hold(panel_hold));
	twsc_top #(.PULSE_CNT(PCNT)) i_twsc_top (.ref_clk(ref_clk), .rstn(rstn),
		.loc_sel(loc_sel),
		.temp_mode(temp_mode), .start_cw(start_cw), .start_ccw(start_ccw),
		.hold_lvl(hold_lvl), .panel_cw(panel_cw), .panel_ccw(panel_ccw),
		.panel_hold(panel_hold), .fault_in(fault_in), .ack_prog(ack_prog),
		.ack_sig(ack_sig), .therm_contact(therm_contact), .tmr_src_bus(tmr_src_bus),
		.tmr1_sel(tmr1_sel), .tmr2_sel(tmr2_sel), .tmr1_mode(tmr1_mode),
		.tmr2_mode(tmr2_mode), .tmr1_time(tmr1_time), .tmr2_time(tmr2_time),
		.run(run), .dir_ccw(dir_ccw), .start_req(start_req), .stop_req(stop_req),
		.fault(fault), .temp_err(temp_err), .temp_warn(temp_warn),
		.tmr1_out(tmr1_out), .tmr2_out(tmr2_out));
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic put(input logic [5:0] v, input int n);
		want <= v;
		cyc(n);
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Every start/stop pulse must match the oldest note; none may come unasked
	always @(negedge ref_clk) begin
		if (start_req === 1'b1 || stop_req === 1'b1) begin
			seen = {start_req, stop_req, run, dir_ccw};
			if (notes.size() == 0) begin
				check("unexpected drive event", 8'h00, {4'h0, seen});
			end else begin
				if (notes[0] == STOP)
					seen[0] = 1'b0;
				check("drive event", {4'h0, notes.pop_front()}, {4'h0, seen});
			end
		end
	end
	initial begin
		#100us;
		n_fail++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(44016));
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		rstn <= 1'b1;
		cyc(2);
		// Plain start mode
		notes.push_back(GO_CW); put(CW, 6);
		notes.push_back(STOP); put(6'h00, 6);
		notes.push_back(GO_CCW); put(CCW, 6);
		notes.push_back(STOP); put(6'h00, 6);
		notes.push_back(GO_CW); put(CW, 4);
		notes.push_back(STOP); put(CW | CCW, 4);
		put(6'h00, 4);
		for (int i = 0; i < 2; i++) begin
			fault_in <= 1'b1;
			cyc(1);
			fault_in <= 1'b0;
			cyc(2);
			check("fault set", 8'h01, {7'h00, fault});
			put(CW, 4);
			put(6'h00, 2);
			if (i == 0) ack_prog <= 1'b1;
			else ack_sig <= 1'b1;
			cyc(1);
			{ack_prog, ack_sig} <= 2'b00;
			cyc(2);
			check("fault cleared", 8'h00, {7'h00, fault});
		end
		// Three-wire from contacts, then from the panel
		for (int k = 0; k < 2; k++) begin
			loc_sel <= k ? twsc_pkg::three_wire_contacts_or_panel
				: twsc_pkg::LOC_THREE_WIRE_CONTACTS;
			h = k ? PHOLD : HOLD;
			c = k ? PCW : CW;
			a = k ? PCCW : CCW;
			put(h, 4);
			notes.push_back(GO_CW); put(h | c, 1 + ($urandom % (PCYC - 1)));
			notes.push_back(STOP); put(h, 4);
			put(6'h00, 4);
			put(h, 4);
			notes.push_back(GO_CCW); put(h | a, PCYC);
			put(h, 4);
			put(h | c, 4);
			put(h | a | c, 4);
			notes.push_back(STOP); put(6'h00, 4);
			put(h, 4);
			notes.push_back(GO_CCW); put(h | a, 3);
			notes.push_back(STOP); put(h | a | c, 4);
			put(h, 4);
			put(6'h00, 4);
			put(h, 4);
			notes.push_back(GO_CW); put(h | c, 4);
			notes.push_back(STOP); put(c, 4);
			put(6'h00, 4);
			put(c, 4);
			put(6'h00, 4);
		end
		loc_sel <= twsc_pkg::LOC_THREE_WIRE_CONTACTS;
		put(PHOLD, 4);
		put(PHOLD | PCW, 4);
		put(HOLD, 4);
		notes.push_back(GO_CW); put(HOLD | CW, 4);
		notes.push_back(STOP);
		fault_in <= 1'b1;
		cyc(1);
		fault_in <= 1'b0;
		put(6'h00, 4);
		ack_prog <= 1'b1;
		cyc(1);
		ack_prog <= 1'b0;
		loc_sel <= 6'h00;
		// Thermal contact into temperature handling
		for (int m = 0; m < 4; m++) begin
			temp_mode <= 2'(m);
			therm_contact <= 1'b1;
			cyc(3);
			check("temp on", {6'h00, 2'(m)}, {6'h00, temp_err, temp_warn});
			therm_contact <= 1'b0;
			cyc(3);
			check("temp off", 8'h00, {6'h00, temp_err, temp_warn});
		end
		// Timers: source select, pass-through and off
		for (int i = 0; i < 8; i++) begin
			tmr_src_bus <= 8'($urandom);
			tmr1_sel <= 3'($urandom);
			tmr2_sel <= 3'($urandom);
			tmr1_mode <= twsc_pkg::TMR_MODE_THRU;
			tmr2_mode <= (i % 2) ? twsc_pkg::TMR_MODE_THRU : twsc_pkg::TMR_MODE_OFF;
			cyc(3);
			check("timer 1", {7'h00, tmr_src_bus[tmr1_sel]}, {7'h00, tmr1_out});
			check("timer 2", {7'h00, tmr_src_bus[tmr2_sel] & tmr2_mode[0]},
				{7'h00, tmr2_out});
		end
		tmr1_mode <= twsc_pkg::TMR_MODE_PULSE;
		tmr2_mode <= twsc_pkg::TMR_MODE_DELAY;
		tmr_src_bus <= 8'h00;
		tmr1_sel <= 3'h0;
		tmr2_sel <= 3'h0;
		cyc(4);
		tmr_src_bus <= 8'h01;
		hi = 0;
		hi2 = 0;
		repeat (20) begin
			cyc(1);
			if (tmr1_out === 1'b1) hi++;
			if (tmr2_out === 1'b1) hi2++;
		end
		check("timer pulse length", 8'h06, 8'(hi));
		check("timer delay high", 8'h10, 8'(hi2));
		check("notes left", 8'h00, 8'(notes.size()));
		wrap_up();
	end
endmodule
